// ===== hdl/tlic_pkg.sv
// package of the two level interrupt controller: offsets, fields, reset values, types
// assumes a byte wide register port with one cycle read latency
package tlic_pkg;
  localparam int NSRC = 6;
  // register offsets (block local)
  localparam logic [2:0] OFS_ENABLE = 3'h0;
  localparam logic [2:0] OFS_PRIORITY = 3'h1;
  localparam logic [2:0] OFS_TRIGGER = 3'h2;
  localparam logic [2:0] OFS_FLAGS = 3'h3;
  localparam logic [2:0] OFS_IRQ_STATUS = 3'h4;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h5;
  localparam logic [2:0] OFS_SERVICE = 3'h6;
  // field positions
  localparam int BIT_GLOBAL_EN = 7;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  // implemented bits of the enable and priority registers
  localparam logic [7:0] ENABLE_MASK = 8'hBF;
  localparam logic [7:0] PRIORITY_MASK = 8'h3F;
  // reset values
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] PRIORITY_RST = 8'h00;
  localparam logic [5:0] SRC_RST = 6'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // vector addresses, lowest source index first
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  // event status bits
  localparam int EVT_ACK = 0;
  localparam int EVT_PREEMPT = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01
  } tlic_state_t;

  // request handed to the core
  typedef struct packed {
    logic valid;
    logic [15:0] vector;
    logic level;
    logic [2:0] source;
  } tlic_req_t;
endpackage

// ===== hdl/tlic_arbiter.sv
// fixed order pick of the first set request within one level
// assumes a purely combinational use by the controller
`timescale 1ns/1ps
module tlic_arbiter (
  // requests, bit 0 highest
  input wire logic [5:0] req,
  // result
  output logic found,
  output logic [2:0] index
);
  // scan from the highest bit down so that the lowest wins
  always_comb
  begin
    found = 1'b0;
    index = 3'h0;
    for (int i = tlic_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        index = 3'(i);
      end
    end
  end
endmodule

// ===== hdl/tlic_core.sv
// two level interrupt controller: enables, priorities, request flags, vector hand-off
// assumes the core pulses VEC_TAKEN when it vectors and RETI_DONE on return
//
// Overview of operation
// - bit 7 of enable register gates all acknowledges; when set, sources follow own bits (a take in the cycle after bit 7 clears is still acknowledged)
// - enable bits 0..5: ext0, timer0, ext1, timer1, serial, timer2
// - vectors 0003H, 000BH, 0013H, 001BH, 0023H, 002BH per source
// - external request is level triggered when type bit 0, edge when 1
// - priority bit 1 selects high level, 0 low level
// - a running service blocks requests of equal or lower level
// - same level ties resolve ext0, timer0, ext1, timer1, serial, timer2
// - priority bits 0..5 follow the same source order
// - priority bits 6, 7 and enable bit 6 are unimplemented
// - timer 0/1 overflow flags set on overflow, cleared when vectored
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module tlic_core (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // register port
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // request sources
  input wire logic EXT_REQUEST_PIN0_N,
  input wire logic EXT_REQUEST_PIN1_N,
  input wire logic TIMER0_OVF,
  input wire logic TIMER1_OVF,
  input wire logic SERIAL_RX_DONE_FLAG,
  input wire logic SERIAL_TX_DONE_FLAG,
  input wire logic TIMER2_OVERFLOW_FLAG,
  input wire logic TIMER2_EXTERNAL_FLAG,
  // core hand-off
  output logic VEC_VALID,
  output logic [15:0] VEC_ADDR,
  input wire logic VEC_TAKEN,
  input wire logic RETI_DONE,
  output logic [1:0] IN_SERVICE,
  // interrupt
  output logic IRQ
);
  typedef struct packed {
    tlic_pkg::tlic_state_t state;
    logic [7:0] enable;
    logic [7:0] priority_lvl;
    logic [1:0] trig_type;
    logic ext0_request_flag;
    logic ext1_request_flag;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic [1:0] pin_prev;
    logic [1:0] in_service;
    logic [2:0] svc_src_lo;
    logic [2:0] svc_src_hi;
    tlic_pkg::tlic_req_t req;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic [7:0] rdata;
  } tlic_state_reg_t;

  tlic_state_reg_t st_reg;
  tlic_state_reg_t st_next;

  logic [5:0] pend;
  logic [5:0] active;
  logic [5:0] req_hi;
  logic [5:0] req_lo;
  logic found_hi;
  logic found_lo;
  logic [2:0] idx_hi;
  logic [2:0] idx_lo;
  logic [1:0] pin_low;
  logic [1:0] pin_fall;

  // vector address of one source
  function automatic logic [15:0] vec_of(input logic [2:0] src);
    vec_of = tlic_pkg::VEC_BASE + 16'(src) * tlic_pkg::VEC_STEP;
  endfunction

  // pending requests in source order
  always_comb
  begin
    pin_low = {~EXT_REQUEST_PIN1_N, ~EXT_REQUEST_PIN0_N};
    pend[tlic_pkg::SRC_EXT0] = st_reg.trig_type[0] ? st_reg.ext0_request_flag : pin_low[0];
    pend[tlic_pkg::SRC_TMR0] = st_reg.timer0_overflow_flag;
    pend[tlic_pkg::SRC_EXT1] = st_reg.trig_type[1] ? st_reg.ext1_request_flag : pin_low[1];
    pend[tlic_pkg::SRC_TMR1] = st_reg.timer1_overflow_flag;
    pend[4] = SERIAL_RX_DONE_FLAG | SERIAL_TX_DONE_FLAG;
    pend[5] = TIMER2_OVERFLOW_FLAG | TIMER2_EXTERNAL_FLAG;
    // global and per source enables; bit 6 is never looked at
    active = st_reg.enable[tlic_pkg::BIT_GLOBAL_EN] ? (pend & st_reg.enable[5:0]) : 6'h00;
    // split by level
    req_hi = active & st_reg.priority_lvl[5:0];
    req_lo = active & ~st_reg.priority_lvl[5:0];
  end

  // falling pin edge per external request
  for (genvar g = 0; g < 2; g++)
  begin : g_edge
    assign pin_fall[g] = pin_low[g] && !st_reg.pin_prev[g];
  end

  // fixed order pick per level
  tlic_arbiter u_arb_hi (
    .req(req_hi),
    .found(found_hi),
    .index(idx_hi)
  );
  tlic_arbiter u_arb_lo (
    .req(req_lo),
    .found(found_lo),
    .index(idx_lo)
  );

  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.pin_prev = pin_low;
    st_next.rdata = 8'h00;
    // edge capture of external requests, set wins over clear
    if (REG_WR && REG_ADDR == tlic_pkg::OFS_FLAGS)
    begin
      if (REG_WDATA[0])
        st_next.ext0_request_flag = 1'b0;
      if (REG_WDATA[1])
        st_next.ext1_request_flag = 1'b0;
      if (REG_WDATA[2])
        st_next.timer0_overflow_flag = 1'b0;
      if (REG_WDATA[3])
        st_next.timer1_overflow_flag = 1'b0;
    end
    // hardware clear on vectoring to an edge or timer source
    if (st_reg.state == tlic_pkg::ST_ACK && VEC_TAKEN)
    begin
      case (st_reg.req.source)
        3'h0:
        begin
          st_next.ext0_request_flag = 1'b0;
        end
        3'h1:
        begin
          st_next.timer0_overflow_flag = 1'b0;
        end
        3'h2:
        begin
          st_next.ext1_request_flag = 1'b0;
        end
        3'h3:
        begin
          st_next.timer1_overflow_flag = 1'b0;
        end
        default:
        begin
          st_next.ext0_request_flag = st_next.ext0_request_flag;
        end
      endcase
    end
    if (pin_fall[0])
      st_next.ext0_request_flag = 1'b1;
    if (pin_fall[1])
      st_next.ext1_request_flag = 1'b1;
    if (TIMER0_OVF)
      st_next.timer0_overflow_flag = 1'b1;
    if (TIMER1_OVF)
      st_next.timer1_overflow_flag = 1'b1;
    // register writes
    if (REG_WR)
    begin
      case (REG_ADDR)
        tlic_pkg::OFS_ENABLE:
        begin
          // bit 6 is kept at zero
          st_next.enable = REG_WDATA & tlic_pkg::ENABLE_MASK;
        end
        tlic_pkg::OFS_PRIORITY:
        begin
          // bits 6 and 7 are kept at zero
          st_next.priority_lvl = REG_WDATA & tlic_pkg::PRIORITY_MASK;
        end
        tlic_pkg::OFS_TRIGGER:
        begin
          // one type bit per external pin
          st_next.trig_type = REG_WDATA[1:0];
        end
        tlic_pkg::OFS_IRQ_STATUS:
        begin
          // write one to clear, events below still set
          st_next.irq_status = st_reg.irq_status & ~REG_WDATA[1:0];
        end
        tlic_pkg::OFS_IRQ_MASK:
        begin
          // one mask bit per event
          st_next.irq_mask = REG_WDATA[1:0];
        end
        default:
        begin
          // flags handled above, others ignored
          st_next.irq_mask = st_next.irq_mask;
        end
      endcase
    end
    // return from the innermost service
    if (RETI_DONE)
    begin
      if (st_reg.in_service[1])
        st_next.in_service[1] = 1'b0;
      else
        st_next.in_service[0] = 1'b0;
    end
    // request and acknowledge sequencing
    case (st_reg.state)
      tlic_pkg::ST_IDLE:
      begin
        if (found_hi && !st_reg.in_service[1])
        begin
          // high level may preempt a low service
          st_next.req.valid = 1'b1;
          st_next.req.level = 1'b1;
          st_next.req.source = idx_hi;
          st_next.req.vector = vec_of(idx_hi);
          st_next.state = tlic_pkg::ST_ACK;
        end
        else if (found_lo && st_reg.in_service == 2'b00)
        begin
          st_next.req.valid = 1'b1;
          st_next.req.level = 1'b0;
          st_next.req.source = idx_lo;
          st_next.req.vector = vec_of(idx_lo);
          st_next.state = tlic_pkg::ST_ACK;
        end
      end
      tlic_pkg::ST_ACK:
      begin
        if (VEC_TAKEN)
        begin
          st_next.req.valid = 1'b0;
          st_next.in_service[st_reg.req.level] = 1'b1;
          st_next.state = tlic_pkg::ST_IDLE;
          st_next.irq_status[tlic_pkg::EVT_ACK] = 1'b1;
          if (st_reg.req.level && st_reg.in_service[0])
            st_next.irq_status[tlic_pkg::EVT_PREEMPT] = 1'b1;
          if (st_reg.req.level)
            st_next.svc_src_hi = st_reg.req.source;
          else
            st_next.svc_src_lo = st_reg.req.source;
        end
        else if (!st_reg.enable[tlic_pkg::BIT_GLOBAL_EN])
        begin
          // withdrawn before the core took it
          st_next.req.valid = 1'b0;
          st_next.state = tlic_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_next.state = tlic_pkg::ST_IDLE;
        st_next.req.valid = 1'b0;
      end
    endcase
    // read data, one cycle later
    if (REG_RD)
    begin
      case (REG_ADDR)
        tlic_pkg::OFS_ENABLE:
        begin
          st_next.rdata = st_reg.enable;
        end
        tlic_pkg::OFS_PRIORITY:
        begin
          st_next.rdata = st_reg.priority_lvl;
        end
        tlic_pkg::OFS_TRIGGER:
        begin
          st_next.rdata = {6'h00, st_reg.trig_type};
        end
        tlic_pkg::OFS_FLAGS:
        begin
          st_next.rdata = {2'h0, pend[5:4], st_reg.timer1_overflow_flag,
            st_reg.timer0_overflow_flag, st_reg.ext1_request_flag, st_reg.ext0_request_flag};
        end
        tlic_pkg::OFS_IRQ_STATUS:
        begin
          st_next.rdata = {6'h00, st_reg.irq_status};
        end
        tlic_pkg::OFS_IRQ_MASK:
        begin
          st_next.rdata = {6'h00, st_reg.irq_mask};
        end
        tlic_pkg::OFS_SERVICE:
        begin
          st_next.rdata = {st_reg.svc_src_hi, st_reg.svc_src_lo,
            st_reg.in_service};
        end
        default:
        begin
          st_next.rdata = 8'h00;
        end
      endcase
    end
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
  end

  // state register
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      st_reg.state <= tlic_pkg::ST_IDLE;
      st_reg.enable <= tlic_pkg::ENABLE_RST;
      st_reg.priority_lvl <= tlic_pkg::PRIORITY_RST;
      st_reg.trig_type <= tlic_pkg::IRQ_RST;
      st_reg.ext0_request_flag <= 1'b0;
      st_reg.ext1_request_flag <= 1'b0;
      st_reg.timer0_overflow_flag <= 1'b0;
      st_reg.timer1_overflow_flag <= 1'b0;
      st_reg.pin_prev <= tlic_pkg::IRQ_RST;
      st_reg.in_service <= tlic_pkg::IRQ_RST;
      st_reg.svc_src_lo <= 3'h0;
      st_reg.svc_src_hi <= 3'h0;
      st_reg.req <= '0;
      st_reg.irq_status <= tlic_pkg::IRQ_RST;
      st_reg.irq_mask <= tlic_pkg::IRQ_RST;
      st_reg.irq <= 1'b0;
      st_reg.rdata <= 8'h00;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from flops
  assign REG_RDATA = st_reg.rdata;
  assign VEC_VALID = st_reg.req.valid;
  assign VEC_ADDR = st_reg.req.vector;
  assign IN_SERVICE = st_reg.in_service;
  assign IRQ = st_reg.irq;
endmodule

// ===== testbench/tlic_core_sva.sv
// checker of the vector hand-off and service nesting
// assumes a bind to tlic_core, one clock domain
`timescale 1ns/1ps
module tlic_core_sva (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // watched ports
  input wire logic REG_WR,
  input wire logic VEC_VALID,
  input wire logic [15:0] VEC_ADDR,
  input wire logic VEC_TAKEN,
  input wire logic RETI_DONE,
  input wire logic [1:0] IN_SERVICE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // offered vectors and their hold
  AST_VEC_SET: assert property (VEC_VALID |-> VEC_ADDR inside {16'h0003,
    16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B}) else $error("vector off table");
  AST_VEC_HOLD: assert property (VEC_VALID && !VEC_TAKEN && !$past(REG_WR) |=>
    VEC_VALID && $stable(VEC_ADDR)) else $error("offer withdrawn");
  // service entry, nesting and return
  AST_TAKE: assert property (VEC_VALID && VEC_TAKEN |=>
    !VEC_VALID && IN_SERVICE != 2'h0) else $error("take not served");
  AST_HI_BLOCK: assert property ($rose(VEC_VALID) |->
    $past(IN_SERVICE) < 2'h2) else $error("offer in high service");
  AST_NEW_SVC: assert property ((IN_SERVICE & ~$past(IN_SERVICE)) != 2'h0 |->
    $past(VEC_VALID) && $past(VEC_TAKEN)) else $error("service without take");
  AST_NEST: assert property (IN_SERVICE == 2'h1 && VEC_VALID && VEC_TAKEN && !RETI_DONE
    |=> IN_SERVICE == 2'h3) else $error("bad nesting");
  AST_RET_HI: assert property (RETI_DONE && IN_SERVICE == 2'h3 |=>
    IN_SERVICE == 2'h1) else $error("return not from high");
  AST_RET_LO: assert property (RETI_DONE && IN_SERVICE == 2'h1 && !VEC_TAKEN |=>
    IN_SERVICE == 2'h0) else $error("return not to idle");
  // main scenarios reached
  COV_TAKE: cover property (VEC_VALID && VEC_TAKEN);
  COV_NEST: cover property (IN_SERVICE == 2'h3);
  COV_RET: cover property (RETI_DONE && IN_SERVICE == 2'h1);
endmodule

// ===== testbench/tlic_core_model.sv
// model of the processor core taking vectors and returning
// assumes the bench picks the take delay and asks for returns
`timescale 1ns/1ps
module tlic_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench controls
  input wire logic [1:0] dly,
  input wire logic ret_req,
  // link
  input wire logic vld,
  input wire logic [1:0] insvc,
  output logic taken,
  output logic reti
);
  logic [1:0] cnt_reg;
  // age of a pending offer
  always_ff @(posedge clk)
  begin
    if (!rstn || !vld)
      cnt_reg <= 2'h0;
    else if (cnt_reg != 2'h3)
      cnt_reg <= cnt_reg + 2'h1;
  end
  // take held over the edge, only while offered
  assign taken = vld && (cnt_reg >= dly);
  // return only from a running service
  assign reti = ret_req && (insvc != 2'h0);
endmodule

// ===== testbench/two_level_interrupt_controller_tb_top.sv
// self-checking bench of the two level interrupt controller
// assumes package, core, checker and core model compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module two_level_interrupt_controller_tb_top;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, en, pr, q;
  logic pin0 = 1'b1, pin1 = 1'b1, t0 = 1'b0, t1 = 1'b0, rq = 1'b0;
  logic [3:0] fl = 4'h0;
  logic [1:0] dly = 2'h0, insvc;
  logic vld, taken, reti, irq;
  logic [15:0] vaddr;
  int seed = 54523, num_errors = 0, check_count = 0;
  // clock
  initial forever #2 clk = ~clk;
  tlic_core uut (.CLK_SYS(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .EXT_REQUEST_PIN0_N(pin0),
    .EXT_REQUEST_PIN1_N(pin1), .TIMER0_OVF(t0), .TIMER1_OVF(t1),
    .SERIAL_RX_DONE_FLAG(fl[0]), .SERIAL_TX_DONE_FLAG(fl[1]),
    .TIMER2_OVERFLOW_FLAG(fl[2]), .TIMER2_EXTERNAL_FLAG(fl[3]), .VEC_VALID(vld),
    .VEC_ADDR(vaddr), .VEC_TAKEN(taken), .RETI_DONE(reti), .IN_SERVICE(insvc), .IRQ(irq));
  tlic_core_model cpu (.clk(clk), .rstn(rstn), .dly(dly), .ret_req(rq), .vld(vld),
    .insvc(insvc), .taken(taken), .reti(reti));
  // register port cycles
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e);
  endtask
  // raise or release sources, pins idle high
  task automatic src(input logic [5:0] r);
    logic s;
    s = 1'($random(seed));
    @(posedge clk);
    pin0 <= !r[0];
    t0 <= r[1];
    pin1 <= !r[2];
    t1 <= r[3];
    fl <= {r[5] & ~s, r[5] & s, r[4] & ~s, r[4] & s};
    @(posedge clk);
    t0 <= 1'b0;
    t1 <= 1'b0;
  endtask
  // first offer seen within a window
  task automatic wv(input logic e, input logic [15:0] v);
    logic seen;
    logic [15:0] got;
    seen = 1'b0;
    got = 16'h0000;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      if (vld === 1'b1 && !seen)
      begin
        seen = 1'b1;
        got = vaddr;
      end
    end
    `CHK(seen, e);
    `CHK(got, v);
  endtask
  task automatic ret();
    @(posedge clk);
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
    #1;
  endtask
  task automatic wirq(input logic [2:0] a, input logic [7:0] d, input logic e);
    wreg(a, d);
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq, e);
  endtask
  // expected vector: high level first, then lowest index
  function automatic logic [15:0] expv(input logic [5:0] m, input logic [5:0] p);
    logic [5:0] s;
    s = ((m & p) != 6'h00) ? (m & p) : m;
    expv = 16'h0000;
    for (int i = 5; i >= 0; i--)
      if (s[i])
        expv = 16'h0003 + 16'(8 * i);
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rreg(tlic_pkg::OFS_ENABLE, 8'h00);
    rreg(tlic_pkg::OFS_PRIORITY, 8'h00);
    wreg(tlic_pkg::OFS_ENABLE, 8'hFF);
    rreg(tlic_pkg::OFS_ENABLE, 8'hBF);
    wreg(tlic_pkg::OFS_PRIORITY, 8'hFF);
    rreg(tlic_pkg::OFS_PRIORITY, 8'h3F);
    rreg(3'h7, 8'h00);
    $display("test regs done");
    repeat (30)
    begin
      en = 8'($random(seed));
      pr = 8'($random(seed));
      q = 8'($random(seed));
      dly <= 2'($random(seed));
      wreg(tlic_pkg::OFS_ENABLE, 8'h00);
      wreg(tlic_pkg::OFS_PRIORITY, {2'h0, pr[5:0]});
      src(q[5:0]);
      wreg(tlic_pkg::OFS_ENABLE, en);
      wv(en[7] && (q[5:0] & en[5:0]) != 6'h00,
        en[7] ? expv(q[5:0] & en[5:0], pr[5:0]) : 16'h0000);
      wreg(tlic_pkg::OFS_ENABLE, 8'h00);
      src(6'h00);
      wreg(tlic_pkg::OFS_FLAGS, 8'h0F);
      ret();
      ret();
    end
    $display("test random done");
    wreg(tlic_pkg::OFS_TRIGGER, 8'h01);
    wreg(tlic_pkg::OFS_PRIORITY, 8'h02);
    @(posedge clk);
    pin0 <= 1'b0;
    repeat (2) @(posedge clk);
    pin0 <= 1'b1;
    repeat (4) @(posedge clk);
    rreg(tlic_pkg::OFS_FLAGS, 8'h01);
    wreg(tlic_pkg::OFS_ENABLE, 8'h87);
    wv(1'b1, 16'h0003);
    rreg(tlic_pkg::OFS_FLAGS, 8'h00);
    src(6'h02);
    wv(1'b1, 16'h000B);
    `CHK(insvc, 2'h3);
    rreg(tlic_pkg::OFS_FLAGS, 8'h00);
    src(6'h04);
    wv(1'b0, 16'h0000);
    ret();
    `CHK(insvc, 2'h1);
    wv(1'b0, 16'h0000);
    ret();
    wv(1'b1, 16'h0013);
    src(6'h00);
    ret();
    // offer withdrawn when the global enable drops before the take
    wreg(tlic_pkg::OFS_ENABLE, 8'h00);
    dly <= 2'h3;
    src(6'h02);
    wreg(tlic_pkg::OFS_ENABLE, 8'h82);
    wreg(tlic_pkg::OFS_ENABLE, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK(vld, 1'b0);
    `CHK(insvc, 2'h0);
    wreg(tlic_pkg::OFS_FLAGS, 8'h0F);
    $display("test nesting done");
    rreg(tlic_pkg::OFS_IRQ_STATUS, 8'h03);
    wirq(tlic_pkg::OFS_IRQ_MASK, 8'h02, 1'b1);
    wirq(tlic_pkg::OFS_IRQ_STATUS, 8'h02, 1'b0);
    wirq(tlic_pkg::OFS_IRQ_MASK, 8'h01, 1'b1);
    wirq(tlic_pkg::OFS_IRQ_STATUS, 8'h01, 1'b0);
    $display("test irq done");
    print_verdict();
  end
endmodule
bind tlic_core tlic_core_sva chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_WR(REG_WR),
  .VEC_VALID(VEC_VALID), .VEC_ADDR(VEC_ADDR), .VEC_TAKEN(VEC_TAKEN),
  .RETI_DONE(RETI_DONE), .IN_SERVICE(IN_SERVICE));
